// [inc/fsp_pkg.sv]
// Package with register offsets, field positions and timing constants.
`default_nettype none
package fsp_pkg;
    // Register word offsets (byte addresses).
    localparam logic [3:0] OFS_TERM_CFG  = 4'h0;
    localparam logic [3:0] OFS_CA_REF    = 4'h4;
    localparam logic [3:0] OFS_POINT_CTL = 4'h8;
    localparam logic [3:0] OFS_RANK_TERM = 4'hc;
    localparam logic [3:0] OFS_STATUS    = 4'h0;
    localparam int ADDR_W = 4;
    // Field positions.
    localparam int CA_TERM_LSB  = 4;
    localparam int CA_TERM_MSB  = 6;
    localparam int REF_LVL_MSB  = 5;
    localparam int REF_RANGE    = 6;
    localparam int FAST_RESP    = 3;
    localparam int WR_POINT     = 6;
    localparam int OP_POINT     = 7;
    localparam int CLK_TERM_BIT = 3;
    localparam int SEL_TERM_BIT = 4;
    localparam int CA_DIS_BIT   = 5;
    // Reset values: unterminated, low frequency, point 0.
    localparam logic [7:0] TERM_CFG_RST  = 8'h00;
    localparam logic [7:0] CA_REF_RST    = 8'h00;
    localparam logic [7:0] POINT_CTL_RST = 8'h00;
    localparam logic [7:0] RANK_TERM_RST = 8'h00;
    localparam logic [2:0] CA_TERM_OFF   = 3'h0;
    // Switch wait classes.
    typedef enum logic [1:0] {
        WAIT_SHORT,
        WAIT_MIDDLE,
        WAIT_LONG
    } wait_class_e;
    // Switch times in ns, clock rate in MHz.
    localparam int SWITCH_TIME_SHORT_NS  = 200;
    localparam int SWITCH_TIME_MIDDLE_NS = 200;
    localparam int SWITCH_TIME_LONG_NS   = 250;
    localparam int CLK_MHZ               = 20;
    localparam int SHORT_CYC  = (SWITCH_TIME_SHORT_NS * CLK_MHZ + 999) / 1000;
    localparam int MIDDLE_CYC = (SWITCH_TIME_MIDDLE_NS * CLK_MHZ + 999) / 1000;
    localparam int LONG_CYC   = (SWITCH_TIME_LONG_NS * CLK_MHZ + 999) / 1000;
endpackage
`default_nettype wire

// [verilog/fsp_classify.sv]
// Classifier of the point switch wait from the two reference settings.
`default_nettype none
module fsp_classify (
    // Reference settings of both points
    input  wire logic [7:0] ref_point0,
    input  wire logic [7:0] ref_point1,
    // Resulting class
    output logic [1:0]      wait_class
);
    logic [5:0] lvl0;
    logic [5:0] lvl1;
    logic [5:0] diff;
    always_comb begin
        lvl0 = ref_point0[fsp_pkg::REF_LVL_MSB:0];
        lvl1 = ref_point1[fsp_pkg::REF_LVL_MSB:0];
        diff = (lvl0 > lvl1) ? lvl0 - lvl1 : lvl1 - lvl0;
        if (ref_point0[fsp_pkg::REF_RANGE] != ref_point1[fsp_pkg::REF_RANGE]) begin
            wait_class = fsp_pkg::WAIT_LONG;
        end else if (diff >= 6'h02) begin
            wait_class = fsp_pkg::WAIT_MIDDLE;
        end else begin
            wait_class = fsp_pkg::WAIT_SHORT;
        end
    end
endmodule
`default_nettype wire

// [verilog/fsp_term_ctrl.sv]
// Set point switching and command bus termination control with Avalon-MM.
// Behaviour
// - One reference step apart selects short wait.
// - Two or more steps select middle wait.
// - Range change selects long wait.
// - Power-up operates from point zero.
// - Both sets reset unterminated, low frequency.
// - Three-bit field selects CA termination, reset off.
// - Termination decided by registers only.
// - Termination covers clocks, select, six CA.
// - Field off disables all; else per-bit disables.
// - Write-point bit selects accessed set independently.
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`default_nettype none
module fsp_term_ctrl (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Termination states
    output logic             ca_term_on,
    output logic [5:0]       ca_pin_term_on,
    output logic             clock_term_on,
    output logic             select_term_on,
    output logic [2:0]       ca_term_value,
    // Operating point state
    output logic             operating_point,
    output logic             reference_fast_response,
    output logic             switch_busy
);
    logic [7:0] term_cfg_reg [2];
    logic [7:0] term_cfg_next [2];
    logic [7:0] ca_ref_reg [2];
    logic [7:0] ca_ref_next [2];
    logic [7:0] rank_term_reg [2];
    logic [7:0] rank_term_next [2];
    logic [7:0] point_ctl_reg;
    logic [7:0] point_ctl_next;
    logic [7:0] wait_cnt_reg;
    logic [7:0] wait_cnt_next;
    logic [1:0] wait_class_reg;
    logic [1:0] wait_class_next;
    logic       ack_reg;
    logic       ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] wait_class;
    logic       wr_set;
    logic       op_set;
    logic       req;

    fsp_classify u_classify (
        .ref_point0 (ca_ref_reg[0]),
        .ref_point1 (ca_ref_reg[1]),
        .wait_class (wait_class)
    );

    always_comb begin
        wr_set = point_ctl_reg[fsp_pkg::WR_POINT];
        op_set = point_ctl_reg[fsp_pkg::OP_POINT];
        req    = avs_read | avs_write;
    end

    // Bus answers one cycle after the request is seen.
    always_comb begin
        term_cfg_next  = term_cfg_reg;
        ca_ref_next    = ca_ref_reg;
        rank_term_next = rank_term_reg;
        point_ctl_next = point_ctl_reg;
        wait_cnt_next  = wait_cnt_reg;
        wait_class_next = wait_class_reg;
        ack_next       = req & ~ack_reg;
        rdata_next     = rdata_reg;
        if (wait_cnt_reg != 8'h00) begin
            wait_cnt_next = wait_cnt_reg - 8'h01;
        end
        if (req & ~ack_reg & avs_read) begin
            unique case (avs_address)
                fsp_pkg::OFS_TERM_CFG: rdata_next = {24'h0, term_cfg_reg[wr_set]};
                fsp_pkg::OFS_CA_REF: rdata_next = {24'h0, ca_ref_reg[wr_set]};
                fsp_pkg::OFS_POINT_CTL: rdata_next = {24'h0, point_ctl_reg};
                fsp_pkg::OFS_RANK_TERM: rdata_next = {24'h0, rank_term_reg[wr_set]};
                default: rdata_next = {22'h0,
                    (wait_cnt_reg != 8'h00) ? wait_class_reg : wait_class,
                    wait_cnt_reg};
            endcase
        end
        if (ack_reg & avs_write) begin
            unique case (avs_address)
                fsp_pkg::OFS_TERM_CFG: term_cfg_next[wr_set] = avs_writedata[7:0];
                fsp_pkg::OFS_CA_REF: ca_ref_next[wr_set] = avs_writedata[7:0];
                fsp_pkg::OFS_RANK_TERM: rank_term_next[wr_set] = avs_writedata[7:0];
                fsp_pkg::OFS_POINT_CTL: begin
                    point_ctl_next = avs_writedata[7:0];
                    if (avs_writedata[fsp_pkg::OP_POINT] != op_set) begin
                        wait_class_next = wait_class;
                        unique case (wait_class)
                            fsp_pkg::WAIT_LONG:
                                wait_cnt_next = 8'(fsp_pkg::LONG_CYC);
                            fsp_pkg::WAIT_MIDDLE:
                                wait_cnt_next = 8'(fsp_pkg::MIDDLE_CYC);
                            default:
                                wait_cnt_next = 8'(fsp_pkg::SHORT_CYC);
                        endcase
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            term_cfg_reg   <= '{fsp_pkg::TERM_CFG_RST, fsp_pkg::TERM_CFG_RST};
            ca_ref_reg     <= '{fsp_pkg::CA_REF_RST, fsp_pkg::CA_REF_RST};
            rank_term_reg  <= '{fsp_pkg::RANK_TERM_RST, fsp_pkg::RANK_TERM_RST};
            point_ctl_reg  <= fsp_pkg::POINT_CTL_RST;
            wait_cnt_reg   <= 8'h00;
            wait_class_reg <= 2'h0;
            ack_reg        <= 1'b0;
            rdata_reg      <= 32'h0;
        end else begin
            term_cfg_reg   <= term_cfg_next;
            ca_ref_reg     <= ca_ref_next;
            rank_term_reg  <= rank_term_next;
            point_ctl_reg  <= point_ctl_next;
            wait_cnt_reg   <= wait_cnt_next;
            wait_class_reg <= wait_class_next;
            ack_reg        <= ack_next;
            rdata_reg      <= rdata_next;
        end
    end

    // Termination is decoded from the operating set only.
    always_comb begin
        ca_term_value  = term_cfg_reg[op_set][fsp_pkg::CA_TERM_MSB:fsp_pkg::CA_TERM_LSB];
        if (ca_term_value == fsp_pkg::CA_TERM_OFF) begin
            ca_term_on     = 1'b0;
            clock_term_on  = 1'b0;
            select_term_on = 1'b0;
        end else begin
            ca_term_on     = ~rank_term_reg[op_set][fsp_pkg::CA_DIS_BIT];
            clock_term_on  = ~rank_term_reg[op_set][fsp_pkg::CLK_TERM_BIT];
            select_term_on = ~rank_term_reg[op_set][fsp_pkg::SEL_TERM_BIT];
        end
        ca_pin_term_on          = {6{ca_term_on}};
        operating_point         = op_set;
        reference_fast_response = point_ctl_reg[fsp_pkg::FAST_RESP];
        switch_busy             = wait_cnt_reg != 8'h00;
        avs_waitrequest         = req & ~ack_reg;
        avs_readdata            = rdata_reg;
    end
endmodule
`default_nettype wire

// [bench/fsp_term_ctrl_asserts.sv]
// Checker of point switching and termination outputs.
`default_nettype none
module fsp_chk (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        ca_term_on,
    input wire logic [5:0]  ca_pin_term_on,
    input wire logic        clock_term_on,
    input wire logic        select_term_on,
    input wire logic [2:0]  ca_term_value,
    input wire logic        operating_point,
    input wire logic        reference_fast_response,
    input wire logic        switch_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire       wr_ok = avs_write && !avs_waitrequest;
    wire       pc_wr = wr_ok && avs_address == 4'h8;
    wire       opn   = avs_writedata[7];
    wire       frn   = avs_writedata[3];
    wire [5:0] terms = {ca_term_value, ca_term_on, clock_term_on,
                        select_term_on};
    pins_a: assert property (ca_pin_term_on == {6{ca_term_on}})
        else $error("CA pin states differ");
    field_off_a: assert property (ca_term_value == 3'h0 |-> terms == 6'h0)
        else $error("Termination on while field is off.");
    regs_only_a: assert property (!wr_ok |=> $stable(terms))
        else $error("Termination changed without a write.");
    reset_state_a: assert property ($fell(sys_rst) |-> terms == 6'h0
        && !operating_point && !switch_busy) else $error("Bad reset state.");
    point_upd_a: assert property (pc_wr |=> operating_point == $past(opn)
        && reference_fast_response == $past(frn)) else $error("Bad point.");
    sw_start_a: assert property (pc_wr && opn != operating_point
        |=> ##[0:1] switch_busy) else $error("Switch wait not started.");
    busy_len_a: assert property ($rose(switch_busy)
        |-> switch_busy[*4] ##[0:2] !switch_busy) else $error("Bad wait.");
    busy_cause_a: assert property ($rose(switch_busy)
        |-> $past(pc_wr) || $past(pc_wr, 2)) else $error("Stray wait.");
endmodule
bind fsp_term_ctrl fsp_chk chk (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .ca_term_on(ca_term_on), .ca_pin_term_on(ca_pin_term_on),
    .clock_term_on(clock_term_on), .select_term_on(select_term_on),
    .ca_term_value(ca_term_value), .operating_point(operating_point),
    .reference_fast_response(reference_fast_response),
    .switch_busy(switch_busy));
`default_nettype wire

// [bench/ctrl_model.sv]
// Memory controller model that issues register requests.
`default_nettype none
module ctrl_model (
    input  wire logic        clk,
    input  wire logic        avs_waitrequest,
    output var  logic [3:0]  avs_address = 4'h0,
    output var  logic        avs_read = 1'b0,
    output var  logic        avs_write = 1'b0,
    output var  logic [31:0] avs_writedata = 32'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Holds a request until waitrequest is sampled low, then drops it.
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !w;
        avs_write <= w;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= ~avs_writedata;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [bench/tb_fsp_switch_and_ca_termination.sv]
// Self-checking bench for point switching and termination control.
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
    error_cnt++; $display("[FAIL] %0t mismatch", $time); end end
module tb_fsp_switch_and_ca_termination;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    wire  [3:0]  avs_address;
    wire         avs_read, avs_write, avs_waitrequest;
    wire  [31:0] avs_writedata, avs_readdata;
    wire         ca_term_on, clock_term_on, select_term_on;
    wire  [5:0]  ca_pin_term_on;
    wire  [2:0]  ca_term_value;
    wire         operating_point, reference_fast_response, switch_busy;
    int          error_cnt = 0;
    int          check_count = 0;
    int          bcnt = 0;
    logic [31:0] rq[$];
    int          bq[$];
    logic [7:0]  r0[4] = '{8'h0c, 8'h0c, 8'h0c, 8'h0e};
    logic [7:0]  r1[4] = '{8'h0d, 8'h0e, 8'h4c, 8'h0d};
    int          cls[4] = '{0, 1, 2, 0};
    logic [2:0]  f, tv[2];
    logic [7:0]  pc;
    always #25 clk = ~clk;
    ctrl_model ctl (.clk(clk), .avs_waitrequest(avs_waitrequest),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata));
    fsp_term_ctrl DUT (.clk(clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ca_term_on(ca_term_on), .ca_pin_term_on(ca_pin_term_on),
        .clock_term_on(clock_term_on), .select_term_on(select_term_on),
        .ca_term_value(ca_term_value), .operating_point(operating_point),
        .reference_fast_response(reference_fast_response),
        .switch_busy(switch_busy));
    always @(posedge clk) begin
        if (avs_read && !avs_waitrequest) `CHK(avs_readdata, rq.pop_front())
        if (switch_busy === 1'b1) bcnt++;
        else if (bcnt > 0) begin
            `CHK(bcnt, bq.pop_front())
            bcnt = 0;
        end
    end
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rq.push_back(e);
        ctl.acc(1'b0, a, 8'h00);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h18b57d3b));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        `CHK({operating_point, switch_busy, ca_term_on}, 3'h0)
        for (int a = 0; a < 4; a++) rd(4'(a * 4), 32'h0);
        $display("reset test done");
        for (int k = 0; k < 9; k++) begin
            f = (k == 8) ? 3'h0 : 3'($urandom_range(6, 1));
            ctl.acc(1'b1, 4'hc, {2'h0, 3'(k), 3'h0});
            ctl.acc(1'b1, 4'h0, {1'b0, f, 4'h0});
            `CHK({ca_term_value, ca_term_on, select_term_on, clock_term_on},
                {f, (f != 3'h0) ? ~3'(k) : 3'h0})
            `CHK(ca_pin_term_on, {6{f != 3'h0 && !k[2]}})
            rd(4'h0, {25'h0, f, 4'h0});
        end
        $display("termination test done");
        pc = 8'h00;
        tv[0] = 3'h0;
        for (int i = 0; i < 4; i++) begin
            ctl.acc(1'b1, 4'h8, pc);
            ctl.acc(1'b1, 4'h4, r0[i]);
            ctl.acc(1'b1, 4'h8, pc | 8'h40);
            ctl.acc(1'b1, 4'h4, r1[i]);
            tv[1] = 3'(i + 1);
            ctl.acc(1'b1, 4'h0, {1'b0, tv[1], 4'h0});
            `CHK(ca_term_value, tv[pc[7]])
            rd(4'h4, {24'h0, r1[i]});
            rd(4'h2, {22'h0, 2'(cls[i]), 8'h0});
            bq.push_back(cls[i] == 2 ? fsp_pkg::LONG_CYC : cls[i] == 1 ?
                fsp_pkg::MIDDLE_CYC : fsp_pkg::SHORT_CYC);
            pc = pc ^ 8'h80;
            ctl.acc(1'b1, 4'h8, pc | 8'h08);
            `CHK({operating_point, reference_fast_response}, {pc[7], 1'b1})
            `CHK({ca_term_value, ca_term_on}, {tv[pc[7]], tv[pc[7]] != 0})
            repeat (fsp_pkg::LONG_CYC + 2) @(posedge clk);
            ctl.acc(1'b1, 4'h8, pc);
            `CHK(reference_fast_response, 1'b0)
        end
        $display("switch test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
